// file: pkg/eptr_defines.vh
// Constants for the encoder position and timer register block
`ifndef EPTR_DEFINES_VH
`define EPTR_DEFINES_VH
// Register byte offsets
`define EPTR_OFF_POS_CNT   8'h00
`define EPTR_OFF_POS_INIT  8'h04
`define EPTR_OFF_POS_MAX   8'h08
`define EPTR_OFF_POS_CMP   8'h0C
`define EPTR_OFF_IDX_LAT   8'h10
`define EPTR_OFF_STB_LAT   8'h14
`define EPTR_OFF_PER_LAT   8'h18
`define EPTR_OFF_UT_CNT    8'h1C
`define EPTR_OFF_UT_PRD    8'h20
`define EPTR_OFF_WD_CNT    8'h24
`define EPTR_OFF_WD_PRD    8'h28
`define EPTR_OFF_INT_EN    8'h2C
`define EPTR_OFF_INT_FLG   8'h30
`define EPTR_OFF_INT_CLR   8'h34
`define EPTR_OFF_CTRL      8'h38
`define EPTR_OFF_CAP_TMR   8'h3C
`define EPTR_OFF_CAP_PRD   8'h40
// Control register fields
`define EPTR_CTL_WD_EN     0
`define EPTR_CTL_UT_EN     1
`define EPTR_CTL_CLM       2
`define EPTR_CTL_STB_SEL   3
`define EPTR_CTL_IDX_LO    4
`define EPTR_CTL_IDX_HI    5
`define EPTR_CTL_SW_INIT   6
`define EPTR_CTL_IDX_INIT  7
`define EPTR_CTL_STB_INIT  8
`define EPTR_CTL_CMP_EN    9
`define EPTR_CTL_MASK      16'h_03BF
// Flag and enable bit positions
`define EPTR_F_UTO         11
`define EPTR_F_IDX         10
`define EPTR_F_STB         9
`define EPTR_F_MATCH       8
`define EPTR_F_RDY         7
`define EPTR_F_OVF         6
`define EPTR_F_UNF         5
`define EPTR_F_WTO         4
`define EPTR_F_GLOBAL      0
`define EPTR_EN_MASK       16'h_0FF0
// Reset values
`define EPTR_RST_32        32'h_0000_0000
`define EPTR_RST_16        16'h_0000
`endif

// file: hw/eptr_regs.v
// Encoder position counter, latches, unit timer and stall watchdog with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "eptr_defines.vh"

module eptr_regs
(
  // Clock, reset and freeze
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // Decoder events, same clock domain, one-cycle pulses except the quad_dir level
  input  wire        quadrature_clock,
  input  wire        quad_dir,
  input  wire        index_rise,
  input  wire        index_fall,
  input  wire        strobe_rise,
  input  wire        strobe_fall,
  // Capture unit values
  input  wire [15:0] capture_timer,
  input  wire [15:0] capture_period,
  // Outputs
  output reg         sync_out,
  output wire        irq
);

  // Software visible state
  reg [31:0] position_counter_r;       // Up/down position
  reg [31:0] position_init_value_r;    // Init value
  reg [31:0] position_maximum_r;       // Wrap limit
  reg [31:0] position_compare_value_r; // Compare value
  reg [31:0] index_position_latch_r;   // Index copy
  reg [31:0] strobe_position_latch_r;  // Strobe copy
  reg [31:0] periodic_position_latch_r;// Timeout copy
  reg [31:0] unit_timer_count_r;       // Time base
  reg [31:0] unit_timer_period_r;      // Time base period
  reg [15:0] stall_watchdog_count_r;   // Stall timer
  reg [15:0] stall_watchdog_period_r;  // Stall period
  reg [15:0] interrupt_enable_mask_r;  // Enable bits
  reg [15:0] interrupt_flags_r;        // Sticky flags
  reg [15:0] decoder_control_r;        // Control bits
  reg [15:0] cap_timer_latch_r;        // Capture timer copy
  reg [15:0] cap_period_latch_r;       // Capture period copy
  reg        match_d_r;                // Previous match state
  reg        done_r;                   // Read data ready

  // Next values
  reg [31:0] position_counter_nxt;
  reg [15:0] flags_nxt;
  reg        ovf_ev;
  reg        unf_ev;

  // Bus decode
  wire       acc    = psel & penable;
  wire       wr_ok  = acc & pready & pwrite;
  wire       rd_pos = acc & pready & ~pwrite & (paddr == `EPTR_OFF_POS_CNT);

  // Returns one for a mapped, word aligned offset
  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `EPTR_OFF_CAP_PRD);
    end
  endfunction

  // Write strobe for one register
  function wsel;
    input [7:0] a;
    input [7:0] off;
    begin
      wsel = (a == off);
    end
  endfunction

  // Control field aliases
  wire wd_en    = decoder_control_r[`EPTR_CTL_WD_EN];
  wire ut_en    = decoder_control_r[`EPTR_CTL_UT_EN];
  wire clm      = decoder_control_r[`EPTR_CTL_CLM];
  wire stb_sel  = decoder_control_r[`EPTR_CTL_STB_SEL];
  wire [1:0] index_event_latch =
    decoder_control_r[`EPTR_CTL_IDX_HI:`EPTR_CTL_IDX_LO];
  wire sw_init  = wr_ok & wsel(paddr, `EPTR_OFF_CTRL) & pwdata[`EPTR_CTL_SW_INIT];

  // Qualified index: 01 rising, 10 falling, 11 both edges
  wire idx_ev = (index_event_latch[0] & index_rise) |
                (index_event_latch[1] & index_fall);
  // Qualified strobe: 0 rising, 1 rising forward / falling reverse
  wire stb_ev = stb_sel ? ((quad_dir & strobe_rise) | (~quad_dir & strobe_fall))
                        : strobe_rise;

  // Initialisation sources
  wire init_ev = sw_init |
                 (decoder_control_r[`EPTR_CTL_IDX_INIT] & index_rise) |
                 (decoder_control_r[`EPTR_CTL_STB_INIT] & strobe_rise);

  // Timer matches
  wire uto_ev = ut_en & (unit_timer_count_r == unit_timer_period_r);
  wire wto_ev = wd_en & ~quadrature_clock &
                (stall_watchdog_count_r == stall_watchdog_period_r);

  // Compare match, event on entry to equality
  wire match    = (position_counter_r == position_compare_value_r);
  wire match_ev = decoder_control_r[`EPTR_CTL_CMP_EN] & match & ~match_d_r;

  // Compare ready: compare value taken by an immediate load
  wire rdy_ev = wr_ok & wsel(paddr, `EPTR_OFF_POS_CMP);

  // Position counter next value with wrap at the maximum
  always @*
  begin
    position_counter_nxt = position_counter_r;
    ovf_ev = 1'b0;
    unf_ev = 1'b0;
    if (init_ev)
    begin
      position_counter_nxt = position_init_value_r;
    end
    else if (quadrature_clock)
    begin
      if (quad_dir)
      begin
        // Count up, wrap to zero past the maximum
        if (position_counter_r == position_maximum_r)
        begin
          position_counter_nxt = `EPTR_RST_32;
          ovf_ev = 1'b1;
        end
        else
        begin
          position_counter_nxt = position_counter_r + 32'h_0000_0001;
        end
      end
      else
      begin
        // Count down, wrap to the maximum below zero
        if (position_counter_r == `EPTR_RST_32)
        begin
          position_counter_nxt = position_maximum_r;
          unf_ev = 1'b1;
        end
        else
        begin
          position_counter_nxt = position_counter_r - 32'h_0000_0001;
        end
      end
    end
  end

  // Flag update: hardware set wins over software clear
  always @*
  begin
    flags_nxt = interrupt_flags_r;
    if (wr_ok & wsel(paddr, `EPTR_OFF_INT_CLR))
    begin
      flags_nxt = interrupt_flags_r & ~pwdata[15:0];
    end
    if (uto_ev)
    begin
      flags_nxt[`EPTR_F_UTO] = 1'b1;
    end
    if (idx_ev)
    begin
      flags_nxt[`EPTR_F_IDX] = 1'b1;
    end
    if (stb_ev)
    begin
      flags_nxt[`EPTR_F_STB] = 1'b1;
    end
    if (match_ev)
    begin
      flags_nxt[`EPTR_F_MATCH] = 1'b1;
    end
    if (rdy_ev)
    begin
      flags_nxt[`EPTR_F_RDY] = 1'b1;
    end
    if (ovf_ev)
    begin
      flags_nxt[`EPTR_F_OVF] = 1'b1;
    end
    if (unf_ev)
    begin
      flags_nxt[`EPTR_F_UNF] = 1'b1;
    end
    if (wto_ev)
    begin
      flags_nxt[`EPTR_F_WTO] = 1'b1;
    end
    // Global status mirrors the request line
    flags_nxt[`EPTR_F_GLOBAL] =
      |(flags_nxt & interrupt_enable_mask_r & `EPTR_EN_MASK);
  end

  // Interrupt request from enabled flags
  assign irq = |(interrupt_flags_r & interrupt_enable_mask_r & `EPTR_EN_MASK);

  // Read path with one wait state so read data comes from a flop
  assign pready = acc & done_r & ce;

  // Bus handshake and read data
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_r  <= 1'b0;
      prdata  <= `EPTR_RST_32;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      if (acc & ~done_r)
      begin
        // First access cycle: capture the read word
        done_r  <= 1'b1;
        pslverr <= ~mapped(paddr);
        case (paddr)
          `EPTR_OFF_POS_CNT:  prdata <= position_counter_r;
          `EPTR_OFF_POS_INIT: prdata <= position_init_value_r;
          `EPTR_OFF_POS_MAX:  prdata <= position_maximum_r;
          `EPTR_OFF_POS_CMP:  prdata <= position_compare_value_r;
          `EPTR_OFF_IDX_LAT:  prdata <= index_position_latch_r;
          `EPTR_OFF_STB_LAT:  prdata <= strobe_position_latch_r;
          `EPTR_OFF_PER_LAT:  prdata <= periodic_position_latch_r;
          `EPTR_OFF_UT_CNT:   prdata <= unit_timer_count_r;
          `EPTR_OFF_UT_PRD:   prdata <= unit_timer_period_r;
          `EPTR_OFF_WD_CNT:   prdata <= {16'h_0000, stall_watchdog_count_r};
          `EPTR_OFF_WD_PRD:   prdata <= {16'h_0000, stall_watchdog_period_r};
          `EPTR_OFF_INT_EN:   prdata <= {16'h_0000, interrupt_enable_mask_r};
          `EPTR_OFF_INT_FLG:  prdata <= {16'h_0000, interrupt_flags_r};
          `EPTR_OFF_CTRL:     prdata <= {16'h_0000, decoder_control_r};
          `EPTR_OFF_CAP_TMR:  prdata <= {16'h_0000, cap_timer_latch_r};
          `EPTR_OFF_CAP_PRD:  prdata <= {16'h_0000, cap_period_latch_r};
          default:            prdata <= `EPTR_RST_32;
        endcase
      end
      else
      begin
        // Completion or idle: drop ready for the next transfer
        done_r  <= 1'b0;
        pslverr <= pslverr & acc & ~done_r;
      end
    end
  end

  // Configuration registers written by software
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      position_init_value_r    <= `EPTR_RST_32;
      position_maximum_r       <= `EPTR_RST_32;
      position_compare_value_r <= `EPTR_RST_32;
      unit_timer_period_r      <= `EPTR_RST_32;
      stall_watchdog_period_r  <= `EPTR_RST_16;
      interrupt_enable_mask_r  <= `EPTR_RST_16;
      decoder_control_r        <= `EPTR_RST_16;
    end
    else if (ce & wr_ok)
    begin
      case (paddr)
        `EPTR_OFF_POS_INIT: position_init_value_r    <= pwdata;
        `EPTR_OFF_POS_MAX:  position_maximum_r       <= pwdata;
        `EPTR_OFF_POS_CMP:  position_compare_value_r <= pwdata;
        `EPTR_OFF_UT_PRD:   unit_timer_period_r      <= pwdata;
        `EPTR_OFF_WD_PRD:   stall_watchdog_period_r  <= pwdata[15:0];
        `EPTR_OFF_INT_EN:
          interrupt_enable_mask_r <= pwdata[15:0] & `EPTR_EN_MASK;
        `EPTR_OFF_CTRL:
          // Init command bit is a strobe and never stored
          decoder_control_r <= pwdata[15:0] & `EPTR_CTL_MASK;
        default:
          decoder_control_r <= decoder_control_r;
      endcase
    end
  end

  // Position counter, latches and flags
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      position_counter_r        <= `EPTR_RST_32;
      index_position_latch_r    <= `EPTR_RST_32;
      strobe_position_latch_r   <= `EPTR_RST_32;
      periodic_position_latch_r <= `EPTR_RST_32;
      cap_timer_latch_r         <= `EPTR_RST_16;
      cap_period_latch_r        <= `EPTR_RST_16;
      interrupt_flags_r         <= `EPTR_RST_16;
      match_d_r                 <= 1'b0;
      sync_out                  <= 1'b0;
    end
    else if (ce)
    begin
      // Software write to the counter wins over counting
      if (wr_ok & wsel(paddr, `EPTR_OFF_POS_CNT))
      begin
        position_counter_r <= pwdata;
      end
      else
      begin
        position_counter_r <= position_counter_nxt;
      end
      // Latches take the value held before this edge
      if (idx_ev)
      begin
        index_position_latch_r <= position_counter_r;
      end
      if (stb_ev)
      begin
        strobe_position_latch_r <= position_counter_r;
      end
      if (uto_ev)
      begin
        periodic_position_latch_r <= position_counter_r;
      end
      // Capture values: on timeout in mode one, on counter read in mode zero
      if ((clm & uto_ev) | (~clm & rd_pos))
      begin
        cap_timer_latch_r  <= capture_timer;
        cap_period_latch_r <= capture_period;
      end
      interrupt_flags_r <= flags_nxt;
      match_d_r         <= match;
      // One-cycle sync pulse on compare match
      sync_out          <= match_ev;
    end
  end

  // Unit timer and stall watchdog
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unit_timer_count_r     <= `EPTR_RST_32;
      stall_watchdog_count_r <= `EPTR_RST_16;
    end
    else if (ce)
    begin
      // Unit timer: software write, restart on match, count when enabled
      if (wr_ok & wsel(paddr, `EPTR_OFF_UT_CNT))
      begin
        unit_timer_count_r <= pwdata;
      end
      else if (uto_ev)
      begin
        unit_timer_count_r <= `EPTR_RST_32;
      end
      else if (ut_en)
      begin
        unit_timer_count_r <= unit_timer_count_r + 32'h_0000_0001;
      end
      // Watchdog: motion clears it, match restarts it
      if (wr_ok & wsel(paddr, `EPTR_OFF_WD_CNT))
      begin
        stall_watchdog_count_r <= pwdata[15:0];
      end
      else if (quadrature_clock | wto_ev)
      begin
        stall_watchdog_count_r <= `EPTR_RST_16;
      end
      else if (wd_en)
      begin
        stall_watchdog_count_r <= stall_watchdog_count_r + 16'h_0001;
      end
    end
  end

endmodule
`default_nettype wire

// file: dv/eptr_regs_sva.sv
// Checker for APB timing and compare pulse of the encoder register block
`timescale 1ns/1ps
`default_nettype none
module eptr_regs_chk (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // APB side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Encoder events and outputs
  input wire logic        quadrature_clock,
  input wire logic        index_rise,
  input wire logic        index_fall,
  input wire logic        strobe_rise,
  input wire logic        strobe_fall,
  input wire logic        sync_out,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Anything that may move the counter or a compare setting
  wire logic mv = quadrature_clock | index_rise | index_fall | strobe_rise | strobe_fall | pready;

  chk_idle_ready: assert property ((!psel || !penable || !ce) |-> !pready)
    else $error("pready outside an access cycle");
  chk_wait_state: assert property ((psel && !penable) |=> !pready)
    else $error("no wait state after setup");
  chk_ready_bound: assert property ((psel && !penable && ce) ##1 (psel && penable && ce) ##1 ce
    |-> pready) else $error("pready late");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready held two cycles");
  chk_slverr_map: assert property (pslverr == (pready && (paddr[1:0] != 2'b00 || paddr > 8'h40)))
    else $error("slave error does not match address map");
  chk_prdata_hold: assert property (!psel |=> $stable(prdata))
    else $error("read data moved while idle");
  chk_ce_freeze: assert property (!ce |=> $stable({prdata, pslverr, sync_out, irq}))
    else $error("state moved while frozen");
  chk_sync_pulse: assert property ((sync_out && ce) |=> !sync_out)
    else $error("sync pulse longer than one cycle");
  chk_sync_cause: assert property ($rose(sync_out) |-> $past(mv, 2))
    else $error("sync pulse without a counter or compare change");
endmodule

bind eptr_regs eptr_regs_chk u_chk (.pclk, .presetn, .ce, .psel, .penable, .paddr, .pready,
  .prdata, .pslverr, .quadrature_clock, .index_rise, .index_fall, .strobe_rise, .strobe_fall,
  .sync_out, .irq);
`default_nettype wire

// file: dv/eptr_enc_model.sv
// Encoder side model: count pulses, index and strobe edges, capture values
`timescale 1ns/1ps
`default_nettype none
module eptr_enc_model (
  // Clock
  input wire logic   pclk,
  // Decoded encoder events
  output logic        quadrature_clock,
  output logic        quad_dir,
  output logic        index_rise,
  output logic        index_fall,
  output logic        strobe_rise,
  output logic        strobe_fall,
  // Capture unit values, changing every cycle
  output logic [15:0] capture_timer,
  output logic [15:0] capture_period
);
  // Quiet outputs at time zero
  initial
  begin
    {quadrature_clock, quad_dir, index_rise, index_fall, strobe_rise, strobe_fall} = '0;
    capture_timer = 16'h0000;
    capture_period = 16'hFFFF;
  end
  // Capture values never sit still
  always @(posedge pclk)
  begin
    capture_timer <= capture_timer + 16'h0001;
    capture_period <= ~capture_timer;
  end
  // Count pulses in one direction, gap idle cycles after each
  task step(input logic d, input int n, input int gap);
    repeat (n)
    begin
      @(posedge pclk);
      quad_dir <= d;
      quadrature_clock <= 1'b1;
      @(posedge pclk);
      quadrature_clock <= 1'b0;
      repeat (gap) @(posedge pclk);
    end
  endtask
  // One-cycle edge event: 0 index rise, 1 index fall, 2 strobe rise, 3 strobe fall
  task edge_ev(input int k);
    @(posedge pclk);
    index_rise <= (k == 0);
    index_fall <= (k == 1);
    strobe_rise <= (k == 2);
    strobe_fall <= (k == 3);
    @(posedge pclk);
    {index_rise, index_fall, strobe_rise, strobe_fall} <= 4'b0000;
  endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Testbench for the encoder position and timer register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk, presetn, ce, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d, v;
  logic        pready, pslverr, sync_out, irq, se;
  logic        quadrature_clock, quad_dir, index_rise, index_fall, strobe_rise, strobe_fall;
  logic [15:0] capture_timer, capture_period;
  int          miscompares, check_count, k;

  eptr_regs uut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .quadrature_clock, .quad_dir, .index_rise, .index_fall, .strobe_rise,
    .strobe_fall, .capture_timer, .capture_period, .sync_out, .irq);
  eptr_enc_model enc (.pclk, .quadrature_clock, .quad_dir, .index_rise, .index_fall,
    .strobe_rise, .strobe_fall, .capture_timer, .capture_period);

  // Verdict and end of run
  task stop_test;
    if (miscompares == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Compare and count
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // One APB transfer, read data left in d, slave error in se; no timeout, only the hang guard ends a stuck wait
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    d = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] x);
    xfer(1'b1, a, x);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(d, e);
  endtask
  // Read one flag bit
  task fl(input int b, input logic e);
    xfer(1'b0, 8'h30, 32'h0000_0000);
    chk(d[b], e);
  endtask

  // Free running clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Hang guard
  initial
  begin
    #200000;
    miscompares++;
    stop_test;
  end
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    miscompares = 0;
    check_count = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, unmapped and unaligned places
    for (k = 0; k <= 56; k += 4) rc(k[7:0], 32'h0000_0000);
    rc(8'h44, 32'h0000_0000);
    chk(se, 1'b1);
    rc(8'h06, 32'h0000_0000);
    chk(se, 1'b1);
    wr(8'h2C, 32'hFFFF_FFFF);
    rc(8'h2C, 32'h0000_0FF0);
    chk(se, 1'b0);
    wr(8'h2C, 32'h0000_0000);
    // Wrap at the maximum both ways
    wr(8'h08, 32'h0000_0004);
    wr(8'h00, 32'h0000_0003);
    enc.step(1'b1, 2, 0);
    rc(8'h00, 32'h0000_0000);
    fl(6, 1'b1);
    enc.step(1'b0, 1, 3);
    rc(8'h00, 32'h0000_0004);
    fl(5, 1'b1);
    enc.step(1'b0, 2, 1);
    rc(8'h00, 32'h0000_0002);
    // Software init, index and strobe latch with init
    wr(8'h08, 32'hFFFF_FFFF);
    wr(8'h04, 32'h1234_5678);
    wr(8'h38, 32'h0000_0040);
    rc(8'h00, 32'h1234_5678);
    wr(8'h00, 32'h0000_0077);
    wr(8'h38, 32'h0000_0090);
    enc.edge_ev(0);
    rc(8'h10, 32'h0000_0077);
    rc(8'h00, 32'h1234_5678);
    fl(10, 1'b1);
    wr(8'h00, 32'h0000_0055);
    wr(8'h38, 32'h0000_0100);
    enc.edge_ev(2);
    rc(8'h14, 32'h0000_0055);
    rc(8'h00, 32'h1234_5678);
    fl(9, 1'b1);
    wr(8'h38, 32'h0000_0020);
    wr(8'h00, 32'h0000_0066);
    enc.edge_ev(1);
    rc(8'h10, 32'h0000_0066);
    rc(8'h00, 32'h0000_0066);
    // Strobe select one while reversing: falling edge latches, rising does not
    wr(8'h38, 32'h0000_0008);
    enc.edge_ev(2);
    rc(8'h14, 32'h0000_0055);
    enc.edge_ev(3);
    rc(8'h14, 32'h0000_0066);
    // Compare match gives sync and flag, mask gates the request
    wr(8'h34, 32'h0000_FFFF);
    wr(8'h0C, 32'h0000_0005);
    wr(8'h00, 32'h0000_0004);
    wr(8'h38, 32'h0000_0200);
    enc.step(1'b1, 1, 0);
    k = 0;
    while (sync_out !== 1'b1 && k < 8)
    begin
      @(negedge pclk);
      k++;
    end
    chk(sync_out, 1'b1);
    fl(8, 1'b1);
    wr(8'h2C, 32'h0000_0100);
    @(negedge pclk);
    chk(irq, 1'b1);
    wr(8'h2C, 32'h0000_0000);
    @(negedge pclk);
    chk(irq, 1'b0);
    // Unit timer with capture latch mode
    wr(8'h34, 32'h0000_FFFF);
    wr(8'h00, 32'h0000_0ABC);
    wr(8'h20, 32'h0000_0014);
    wr(8'h38, 32'h0000_0006);
    repeat (25) @(posedge pclk);
    fl(11, 1'b1);
    rc(8'h18, 32'h0000_0ABC);
    xfer(1'b0, 8'h1C, 32'h0000_0000);
    chk(d <= 32'h0000_0014, 1'b1);
    wr(8'h38, 32'h0000_0000);
    // Capture timer and period copies come from one edge
    xfer(1'b0, 8'h3C, 32'h0000_0000);
    v = d;
    rc(8'h40, {16'h0000, ~(v[15:0] - 16'h0001)});
    wr(8'h34, 32'h0000_FFFF);
    xfer(1'b0, 8'h1C, 32'h0000_0000);
    v = d;
    repeat (30) @(posedge pclk);
    rc(8'h1C, v);
    fl(11, 1'b0);
    // Freeze for a few cycles
    @(posedge pclk);
    ce <= 1'b0;
    repeat (5) @(posedge pclk);
    ce <= 1'b1;
    // Stall watchdog
    wr(8'h28, 32'h0000_001E);
    rc(8'h28, 32'h0000_001E);
    wr(8'h38, 32'h0000_0001);
    enc.step(1'b1, 8, 12);
    fl(4, 1'b0);
    repeat (40) @(posedge pclk);
    fl(4, 1'b1);
    wr(8'h38, 32'h0000_0000);
    wr(8'h34, 32'h0000_FFFF);
    repeat (40) @(posedge pclk);
    fl(4, 1'b0);
    stop_test;
  end
endmodule
`default_nettype wire
